//--- src/sysctl_pkg.sv
package sysctl_pkg;
    // register offsets (byte addresses, one word each)
    localparam logic [7:0] ADDR_OSC_TRIM_CMD = 8'h00;
    localparam logic [7:0] ADDR_OSC_TRIM_STAT = 8'h04;
    localparam logic [7:0] ADDR_PWM_DIV = 8'h08;
    localparam logic [7:0] ADDR_SW_RESET = 8'h0c;
    localparam logic [7:0] ADDR_RST_BEHAV = 8'h10;
    localparam logic [7:0] ADDR_RST_CAUSE = 8'h14;
    localparam logic [7:0] ADDR_SLEEP_CTRL = 8'h18;
    localparam logic [7:0] ADDR_SLEEP_PWR = 8'h1c;
    localparam logic [7:0] ADDR_PERIPH_SLEEP_EN = 8'h20;
    // trim command field layout
    localparam int TRIM_CMD_AUTO_BIT = 8;
    localparam int TRIM_CMD_FACT_BIT = 9;
    localparam int TRIM_CMD_USER_BIT = 10;
    localparam logic [6:0] TRIM_NOMINAL = 7'h40;
    // trim status layout
    localparam int TRIM_STAT_OK_BIT = 0;
    localparam int TRIM_STAT_BUSY_BIT = 1;
    localparam int TRIM_STAT_VAL_LSB = 8;
    // auto trim: count sys_clk cycles over a window of 32 reference periods
    localparam int REF_PERIODS = 32;
    localparam real SYS_CLK_MHZ = 40.0;
    localparam real REF_CLK_KHZ = 32.768;
    localparam int AUTO_TARGET = int'(SYS_CLK_MHZ * 1000.0 * REF_PERIODS / REF_CLK_KHZ);
    localparam int AUTO_TIMEOUT = 2 * AUTO_TARGET;
    localparam int AUTO_TOL = 4;
    // pwm divider encoding: log2 of the ratio, 0..6
    localparam logic [2:0] PWM_DIV_MAX = 3'h6;
    localparam logic [2:0] PWM_DIV_RESET = 3'h0;
    // reset behaviour layout: per source a set strobe bit and a value bit
    localparam int NUM_RST_SRC = 4;
    localparam int BEHAV_SEL_LSB = 4;
    localparam logic [3:0] BEHAV_DEFAULT = 4'h0;
    // cause flag positions
    localparam int CAUSE_EXT = 0;
    localparam int CAUSE_POR = 1;
    localparam int CAUSE_BOR = 2;
    localparam int CAUSE_WDOG0 = 3;
    localparam int CAUSE_SW = 4;
    localparam int CAUSE_WDOG1 = 5;
    localparam int CAUSE_HIB = 6;
    localparam int CAUSE_HSRV = 7;
    localparam logic [31:0] SW_RESET_KEY = 32'h0000_0001;
    localparam int NUM_PERIPH = 16;
    localparam logic [1:0] SRAM_FULL = 2'h0;
    localparam logic [1:0] SRAM_STANDBY = 2'h1;
    localparam logic [1:0] SRAM_LOWEST = 2'h3;
    typedef enum logic [2:0] {
        TRIM_IDLE = 3'b001,
        TRIM_AUTO = 3'b010,
        TRIM_DONE = 3'b100
    } trim_state_t;
endpackage : sysctl_pkg

//--- src/reset_clock_sleep_control.sv
// Contract
// [R1] auto trim against 32 kHz reference
// [R2] auto trim fails without running hibernation
// [R3] factory request restores manufactured trim
// [R4] user mode loads 7-bit trim, 0x40 nominal
// [R5] higher code lowers frequency, monotonic
// [R6] outcome reported: 1 success, 0 fail
// [R7] pwm clock divides by 1..64 powers
// [R8] divider readback is an allowed ratio
// [R9] software reset resets whole device
// [R10] software reset keeps causes, sets sw flag
// [R11] per source system or power-on select
// [R12] behaviour write changes selected sources only
// [R13] behaviour readable as one value
// [R14] cause flags sticky until clear or power-on (code also clears them on the reset input)
// [R15] cause clear by mask only
// [R16] eight distinct cause flags
// [R17] sleep gating keeps sleep-enabled clocks only
// [R18] running peripheral wake returns to run
// [R19] flash full or low power in sleep
// [R20] sram full, standby or lowest in sleep
// [R21] stopped peripheral resumes with state kept
// [R22] divider changes at divided-clock boundary
// [R23] sleep and behaviour survive system reset (code keeps them across software reset only; the reset input clears them)
`timescale 1ns/1ps
`default_nettype none
module reset_clock_sleep_control
    import sysctl_pkg::*;
(
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [31:0] reg_rdata,
    input wire logic power_on_event,
    input wire logic src_ext_pin,
    input wire logic src_brownout,
    input wire logic src_watchdog0,
    input wire logic src_watchdog1,
    input wire logic src_hibernation,
    input wire logic src_service_req,
    input wire logic hib_present,
    input wire logic hib_enabled,
    input wire logic hib_rtc_running,
    input wire logic ref_clk_32k,
    input wire logic [6:0] factory_trim,
    output logic [6:0] osc_trim,
    output logic pwm_clk_en,
    output logic system_reset_req,
    output logic full_power_on_req,
    input wire logic sleep_req,
    input wire logic [NUM_PERIPH-1:0] periph_run_en,
    input wire logic [NUM_PERIPH-1:0] periph_wake,
    output logic [NUM_PERIPH-1:0] periph_clk_en,
    output logic sleeping,
    output logic flash_low_power,
    output logic [1:0] sram_power
);
    // a system reset returns registers to default; a software reset keeps behaviour, sleep power and causes; reset clears all, power-on also sets its cause flag
    logic sys_rst;
    logic wr_trim, wr_pwm, wr_sw, wr_behav, wr_cause, wr_sctl, wr_spwr, wr_pse;
    trim_state_t trim_state_q;
    logic [6:0] trim_q;
    logic trim_ok_q;
    // wide enough for the timeout count, which does not fit in 16 bits
    logic [16:0] auto_cnt_q;
    logic [5:0] ref_edges_q;
    logic ref_q1, ref_q2, ref_q3;
    logic [2:0] pwm_sel_q, pwm_pend_q;
    logic [5:0] pwm_cnt_q;
    logic [3:0] behav_q;
    logic [7:0] cause_q;
    logic gating_q;
    logic flash_lp_q;
    logic [1:0] sram_q;
    logic [NUM_PERIPH-1:0] sleep_en_q;
    logic sleep_q;
    logic sleep_d;
    logic flash_out_q;
    logic [1:0] sram_out_q;
    logic sw_rst_q, sys_req_q, por_req_q;
    logic [6:0] osc_trim_q;
    logic pwm_en_q;
    logic [NUM_PERIPH-1:0] pclk_q;

    function automatic logic [5:0] div_mask(input logic [2:0] sel);
        div_mask = 6'((7'h01 << sel) - 7'h01);
    endfunction : div_mask

    function automatic logic wr_hit(input logic [7:0] a);
        wr_hit = reg_write && (reg_addr == a);
    endfunction : wr_hit

    assign sys_rst = reset || sw_rst_q || power_on_event;
    assign wr_trim = wr_hit(ADDR_OSC_TRIM_CMD);
    assign wr_pwm = wr_hit(ADDR_PWM_DIV);
    assign wr_sw = wr_hit(ADDR_SW_RESET) && (reg_wdata == SW_RESET_KEY);
    assign wr_behav = wr_hit(ADDR_RST_BEHAV);
    assign wr_cause = wr_hit(ADDR_RST_CAUSE);
    assign wr_sctl = wr_hit(ADDR_SLEEP_CTRL);
    assign wr_spwr = wr_hit(ADDR_SLEEP_PWR);
    assign wr_pse = wr_hit(ADDR_PERIPH_SLEEP_EN);

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            ref_q1 <= 1'b0;
            ref_q2 <= 1'b0;
            ref_q3 <= 1'b0;
        end else begin
            ref_q1 <= ref_clk_32k;
            ref_q2 <= ref_q1;
            ref_q3 <= ref_q2;
        end
    end

    // trim sequencer
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            trim_state_q <= TRIM_IDLE;
            trim_q <= TRIM_NOMINAL;
            trim_ok_q <= 1'b0;
            auto_cnt_q <= 17'h00000;
            ref_edges_q <= 6'h00;
        end else begin
            unique case (trim_state_q)
                TRIM_IDLE: begin
                    if (wr_trim && reg_wdata[TRIM_CMD_FACT_BIT]) begin
                        // [R3] factory trim restore
                        trim_q <= factory_trim;
                        trim_ok_q <= 1'b1;
                    end else if (wr_trim && reg_wdata[TRIM_CMD_USER_BIT]) begin
                        // [R4] user 7-bit load
                        trim_q <= reg_wdata[6:0];
                        trim_ok_q <= 1'b1;
                    end else if (wr_trim && reg_wdata[TRIM_CMD_AUTO_BIT]) begin
                        // [R2] reference preconditions
                        if (hib_present && hib_enabled && hib_rtc_running) begin
                            trim_state_q <= TRIM_AUTO;
                            auto_cnt_q <= 17'h00000;
                            ref_edges_q <= 6'h00;
                        end else begin
                            // [R6] failure outcome
                            trim_ok_q <= 1'b0;
                        end
                    end
                end
                TRIM_AUTO: begin
                    auto_cnt_q <= auto_cnt_q + 17'h00001;
                    if (ref_q2 && !ref_q3) begin
                        ref_edges_q <= ref_edges_q + 6'h01;
                    end
                    // [R1] compare count with reference window
                    if (ref_edges_q == 6'(REF_PERIODS)) begin
                        trim_state_q <= TRIM_DONE;
                        // [R5] fast osc means raise code
                        if (auto_cnt_q > 17'(AUTO_TARGET + AUTO_TOL) && trim_q != 7'h7f) begin
                            trim_q <= trim_q + 7'h01;
                        end else if (auto_cnt_q + 17'(AUTO_TOL) < 17'(AUTO_TARGET)
                                     && trim_q != 7'h00) begin
                            trim_q <= trim_q - 7'h01;
                        end
                        trim_ok_q <= 1'b1;
                    end else if (auto_cnt_q == 17'(AUTO_TIMEOUT) || !hib_rtc_running) begin
                        // [R2] missing reference fails
                        trim_state_q <= TRIM_DONE;
                        trim_ok_q <= 1'b0;
                    end
                end
                TRIM_DONE: begin
                    trim_state_q <= TRIM_IDLE;
                end
            endcase
        end
    end

    // [R22] divider update at boundary
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            pwm_sel_q <= PWM_DIV_RESET;
            pwm_pend_q <= PWM_DIV_RESET;
            pwm_cnt_q <= 6'h00;
            pwm_en_q <= 1'b0;
        end else begin
            // [R7] only ratios up to 64
            if (wr_pwm && reg_wdata[2:0] <= PWM_DIV_MAX) begin
                pwm_pend_q <= reg_wdata[2:0];
            end
            if ((pwm_cnt_q & div_mask(pwm_sel_q)) == div_mask(pwm_sel_q)) begin
                pwm_cnt_q <= 6'h00;
                pwm_en_q <= 1'b1;
                pwm_sel_q <= pwm_pend_q;
            end else begin
                pwm_cnt_q <= pwm_cnt_q + 6'h01;
                pwm_en_q <= 1'b0;
            end
        end
    end

    // [R9] software reset pulse
    always_ff @(posedge sys_clk) begin
        if (reset || power_on_event) begin
            sw_rst_q <= 1'b0;
        end else begin
            sw_rst_q <= wr_sw;
        end
    end

    // [R23] retained across software reset, cleared by reset and power-on
    always_ff @(posedge sys_clk) begin
        if (power_on_event || reset) begin
            behav_q <= BEHAV_DEFAULT;
            flash_lp_q <= 1'b0;
            sram_q <= SRAM_FULL;
        end else begin
            if (wr_behav) begin
                for (int i = 0; i < NUM_RST_SRC; i++) begin
                    // [R12] selected sources only
                    if (reg_wdata[i]) begin
                        // [R11] per source type
                        behav_q[i] <= reg_wdata[BEHAV_SEL_LSB + i];
                    end
                end
            end
            if (wr_spwr) begin
                // [R19] flash sleep power
                flash_lp_q <= reg_wdata[0];
                // [R20] sram state, illegal code held off
                if (reg_wdata[5:4] != 2'h2) begin
                    sram_q <= reg_wdata[5:4];
                end
            end
        end
    end

    // configurable source request routing
    always_ff @(posedge sys_clk) begin
        if (reset || power_on_event) begin
            sys_req_q <= 1'b0;
            por_req_q <= 1'b0;
        end else begin
            sys_req_q <= (src_watchdog0 && !behav_q[0]) || (src_watchdog1 && !behav_q[1])
                       || (src_brownout && !behav_q[2]) || (src_ext_pin && !behav_q[3]);
            por_req_q <= (src_watchdog0 && behav_q[0]) || (src_watchdog1 && behav_q[1])
                       || (src_brownout && behav_q[2]) || (src_ext_pin && behav_q[3]);
        end
    end

    // [R14] sticky causes; power-on leaves only its own flag
    always_ff @(posedge sys_clk) begin
        if (power_on_event) begin
            cause_q <= 8'h00;
            cause_q[CAUSE_POR] <= 1'b1;
        end else if (reset) begin
            cause_q <= 8'h00;
        end else begin
            for (int i = 0; i < 8; i++) begin
                // [R15] masked clear
                if (wr_cause && reg_wdata[i]) begin
                    cause_q[i] <= 1'b0;
                end
            end
            // [R16] distinct flags, set wins over clear
            if (src_ext_pin) cause_q[CAUSE_EXT] <= 1'b1;
            if (src_brownout) cause_q[CAUSE_BOR] <= 1'b1;
            if (src_watchdog0) cause_q[CAUSE_WDOG0] <= 1'b1;
            if (src_watchdog1) cause_q[CAUSE_WDOG1] <= 1'b1;
            if (src_hibernation) cause_q[CAUSE_HIB] <= 1'b1;
            if (src_service_req) cause_q[CAUSE_HSRV] <= 1'b1;
            // [R10] software flag added
            if (wr_sw) cause_q[CAUSE_SW] <= 1'b1;
        end
    end

    // sleep next state, shared by the sleep flag and the power outputs
    always_comb begin
        sleep_d = sleep_q;
        if (sleep_q && |(periph_wake & pclk_q)) begin
            sleep_d = 1'b0;
        end else if (sleep_req) begin
            sleep_d = 1'b1;
        end
    end

    // power outputs registered, low power only while asleep
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            flash_out_q <= 1'b0;
            sram_out_q <= SRAM_FULL;
        end else begin
            flash_out_q <= flash_lp_q && sleep_d;
            sram_out_q <= sleep_d ? sram_q : SRAM_FULL;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            gating_q <= 1'b0;
            sleep_en_q <= '0;
            sleep_q <= 1'b0;
            pclk_q <= '0;
        end else begin
            if (wr_sctl) gating_q <= reg_wdata[0];
            if (wr_pse) sleep_en_q <= reg_wdata[NUM_PERIPH-1:0];
            // [R18] wake from running peripheral
            sleep_q <= sleep_d;
            // [R17] sleep clock gating
            if (sleep_q && gating_q) begin
                pclk_q <= periph_run_en & sleep_en_q;
            end else begin
                // [R21] clocks resume, state untouched
                pclk_q <= periph_run_en;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            osc_trim_q <= TRIM_NOMINAL;
        end else begin
            osc_trim_q <= trim_q;
        end
    end

    // read port, data one cycle after strobe
    always_ff @(posedge sys_clk) begin
        if (reset || power_on_event) begin
            reg_rdata <= 32'h0000_0000;
        end else if (reg_read) begin
            unique case (reg_addr)
                ADDR_OSC_TRIM_STAT: begin
                    reg_rdata <= {16'h0000, 1'b0, trim_q, 6'h00,
                                  trim_state_q != TRIM_IDLE, trim_ok_q};
                end
                // [R8] current divider readback
                ADDR_PWM_DIV: reg_rdata <= {29'h0, pwm_sel_q};
                // [R13] combined behaviour readback
                ADDR_RST_BEHAV: reg_rdata <= {24'h0, behav_q, 4'h0};
                ADDR_RST_CAUSE: reg_rdata <= {24'h0, cause_q};
                ADDR_SLEEP_CTRL: reg_rdata <= {30'h0, sleep_q, gating_q};
                ADDR_SLEEP_PWR: reg_rdata <= {26'h0, sram_q, 3'h0, flash_lp_q};
                ADDR_PERIPH_SLEEP_EN: reg_rdata <= {16'h0, sleep_en_q};
                default: reg_rdata <= 32'h0000_0000;
            endcase
        end else begin
            reg_rdata <= 32'h0000_0000;
        end
    end

    assign osc_trim = osc_trim_q;
    assign pwm_clk_en = pwm_en_q;
    assign system_reset_req = sys_req_q;
    assign full_power_on_req = por_req_q;
    assign periph_clk_en = pclk_q;
    assign sleeping = sleep_q;
    assign flash_low_power = flash_out_q;
    assign sram_power = sram_out_q;
endmodule : reset_clock_sleep_control
`default_nettype wire

//--- tb/reset_clock_sleep_control_checker.sv
`timescale 1ns/1ps
`default_nettype none
module reset_clock_sleep_control_checker
    import sysctl_pkg::*;
(
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    input wire logic [31:0] reg_rdata,
    input wire logic [6:0] osc_trim,
    input wire logic pwm_clk_en,
    input wire logic src_ext_pin,
    input wire logic src_brownout,
    input wire logic src_watchdog0,
    input wire logic src_watchdog1,
    input wire logic system_reset_req,
    input wire logic full_power_on_req,
    input wire logic [NUM_PERIPH-1:0] periph_run_en,
    input wire logic [NUM_PERIPH-1:0] periph_wake,
    input wire logic [NUM_PERIPH-1:0] periph_clk_en,
    input wire logic sleeping,
    input wire logic flash_low_power,
    input wire logic [1:0] sram_power
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);
    // cycles since the last divided pwm pulse
    logic [6:0] gap_q;
    always_ff @(posedge sys_clk) begin
        if (reset || pwm_clk_en) begin
            gap_q <= 7'h00;
        end else begin
            gap_q <= gap_q + 7'h01;
        end
    end
    a_rdata_idle_zero:
        assert property (!reg_read |=> reg_rdata == 32'h0)
        else $error("read data outside its slot");
    a_trim_reset_nominal:
        assert property ($fell(reset) |-> osc_trim == TRIM_NOMINAL)
        else $error("trim not nominal after reset");
    a_user_trim_load:
        assert property (reg_write && reg_addr == ADDR_OSC_TRIM_CMD
            && reg_wdata[TRIM_CMD_USER_BIT] && !reg_wdata[TRIM_CMD_FACT_BIT]
            |-> ##3 osc_trim == $past(reg_wdata[6:0], 3))
        else $error("user trim not loaded");
    a_event_one_req:
        assert property ((src_ext_pin || src_brownout || src_watchdog0 || src_watchdog1)
            |-> ##[1:3] (system_reset_req ^ full_power_on_req))
        else $error("reset event without one request");
    a_pwm_gap_bound:
        assert property (gap_q < 7'h40)
        else $error("pwm pulse gap above 64");
    a_wake_exit:
        assert property (sleeping && (|(periph_wake & periph_clk_en)) |=> !sleeping)
        else $error("wake did not end sleep");
    a_power_awake:
        assert property (!sleeping |-> !flash_low_power && sram_power == SRAM_FULL)
        else $error("low power while awake");
    a_clk_awake:
        assert property (!sleeping ##1 !sleeping |-> periph_clk_en == $past(periph_run_en))
        else $error("clock enable not run enable");
endmodule : reset_clock_sleep_control_checker
bind reset_clock_sleep_control reset_clock_sleep_control_checker
    u_reset_clock_sleep_control_checker (.*);
`default_nettype wire

//--- tb/tb_reset_clock_sleep_control.sv
`timescale 1ns/1ps
`default_nettype none
module tb_reset_clock_sleep_control
    import sysctl_pkg::*;
;
    logic sys_clk = 1'h0;
    logic reset = 1'h1;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic [31:0] reg_rdata;
    logic reg_write = 1'h0, reg_read = 1'h0, power_on_event = 1'h0;
    logic src_ext_pin = 1'h0, src_brownout = 1'h0, src_watchdog0 = 1'h0;
    logic src_watchdog1 = 1'h0, src_hibernation = 1'h0, src_service_req = 1'h0;
    logic hib_present = 1'h1, hib_enabled = 1'h1, hib_rtc_running = 1'h0;
    logic ref_clk_32k = 1'h0, sleep_req = 1'h0;
    logic [6:0] factory_trim = 7'h55;
    logic [6:0] osc_trim;
    logic pwm_clk_en, system_reset_req, full_power_on_req, sleeping, flash_low_power;
    logic [1:0] sram_power;
    logic [15:0] periph_run_en = 16'h0, periph_wake = 16'h0, periph_clk_en;
    int n_fail = 0;
    int compares = 0;
    reset_clock_sleep_control u_reset_clock_sleep_control (.*);
    initial forever #12.5 sys_clk = ~sys_clk;
    initial forever #15259 ref_clk_32k = ~ref_clk_32k;
    task automatic close_out();
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : close_out
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'h1;
        @(posedge sys_clk);
        reg_write <= 1'h0;
        @(posedge sys_clk);
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        reg_addr <= a;
        reg_read <= 1'h1;
        @(posedge sys_clk);
        reg_read <= 1'h0;
        #1 d = reg_rdata;
        @(posedge sys_clk);
    endtask : rd
    task automatic rc(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] d;
        rd(a, d);
        chk(d, e);
    endtask : rc
    task automatic trim_wait(input logic ok);
        logic [31:0] d;
        repeat (4) @(posedge sys_clk);
        for (int i = 0; i < 30000; i++) begin
            rd(ADDR_OSC_TRIM_STAT, d);
            if (d[TRIM_STAT_BUSY_BIT] === 1'h0) begin
                chk({31'h0, d[TRIM_STAT_OK_BIT]}, {31'h0, ok});
                return;
            end
        end
        n_fail++;
        close_out();
    endtask : trim_wait
    task automatic pwm_gap(input logic [31:0] e);
        logic [31:0] c;
        c = 32'h0;
        while (pwm_clk_en !== 1'h1 && c < 32'h80) begin
            @(negedge sys_clk);
            c++;
        end
        @(negedge sys_clk);
        c = 32'h1;
        while (pwm_clk_en !== 1'h1 && c < 32'h80) begin
            @(negedge sys_clk);
            c++;
        end
        chk(c, e);
        @(posedge sys_clk);
    endtask : pwm_gap
    task automatic hit(input logic [3:0] s, input logic [1:0] e);
        logic [1:0] seen;
        seen = 2'h0;
        {src_ext_pin, src_brownout, src_watchdog1, src_watchdog0} <= s;
        @(posedge sys_clk);
        {src_ext_pin, src_brownout, src_watchdog1, src_watchdog0} <= 4'h0;
        repeat (4) begin
            @(negedge sys_clk);
            seen = seen | {full_power_on_req, system_reset_req};
        end
        @(posedge sys_clk);
        chk({30'h0, seen}, {30'h0, e});
    endtask : hit
    task automatic nap();
        sleep_req <= 1'h1;
        @(posedge sys_clk);
        sleep_req <= 1'h0;
        repeat (3) @(posedge sys_clk);
        #1;
    endtask : nap
    task automatic t_reset_vals();
        chk({25'h0, osc_trim}, {25'h0, TRIM_NOMINAL});
        rc(ADDR_PWM_DIV, 32'h0);
        rc(ADDR_RST_BEHAV, 32'h0);
        wr(8'h3c, 32'hffff_ffff);
        rc(8'h3c, 32'h0);
    endtask : t_reset_vals
    task automatic t_trim();
        wr(ADDR_OSC_TRIM_CMD, 32'h0000_0423);
        repeat (3) @(posedge sys_clk);
        chk({25'h0, osc_trim}, 32'h23);
        rc(ADDR_OSC_TRIM_STAT, 32'h0000_2301);
        wr(ADDR_OSC_TRIM_CMD, 32'h0000_0200);
        repeat (3) @(posedge sys_clk);
        chk({25'h0, osc_trim}, 32'h55);
        wr(ADDR_OSC_TRIM_CMD, 32'h0000_0100);
        trim_wait(1'h0);
        hib_rtc_running <= 1'h1;
        wr(ADDR_OSC_TRIM_CMD, 32'h0000_0100);
        trim_wait(1'h1);
    endtask : t_trim
    task automatic t_pwm();
        for (int k = 0; k < 7; k++) begin
            wr(ADDR_PWM_DIV, 32'(k));
            repeat (70) @(posedge sys_clk);
            rc(ADDR_PWM_DIV, 32'(k));
            pwm_gap(32'h1 << k);
        end
        wr(ADDR_PWM_DIV, 32'h7);
        repeat (70) @(posedge sys_clk);
        rc(ADDR_PWM_DIV, 32'h6);
        wr(ADDR_PWM_DIV, 32'h3);
    endtask : t_pwm
    task automatic t_behav();
        wr(ADDR_RST_BEHAV, 32'h11);
        rc(ADDR_RST_BEHAV, 32'h10);
        wr(ADDR_RST_BEHAV, 32'h8c);
        rc(ADDR_RST_BEHAV, 32'h90);
        hit(4'h1, 2'h2);
        hit(4'h4, 2'h1);
        hit(4'h8, 2'h2);
    endtask : t_behav
    task automatic t_cause();
        wr(ADDR_RST_CAUSE, 32'hff);
        rc(ADDR_RST_CAUSE, 32'h0);
        src_hibernation <= 1'h1;
        src_service_req <= 1'h1;
        @(posedge sys_clk);
        src_hibernation <= 1'h0;
        src_service_req <= 1'h0;
        hit(4'h2, 2'h1);
        hit(4'h8, 2'h2);
        rc(ADDR_RST_CAUSE, 32'he1);
        wr(ADDR_RST_CAUSE, 32'h01);
        rc(ADDR_RST_CAUSE, 32'he0);
    endtask : t_cause
    task automatic t_swreset();
        wr(ADDR_SLEEP_PWR, 32'h31);
        wr(ADDR_SW_RESET, SW_RESET_KEY);
        repeat (4) @(posedge sys_clk);
        rc(ADDR_RST_CAUSE, 32'hf0);
        rc(ADDR_RST_BEHAV, 32'h90);
        rc(ADDR_PWM_DIV, 32'h0);
        chk({25'h0, osc_trim}, {25'h0, TRIM_NOMINAL});
    endtask : t_swreset
    task automatic t_sleep();
        periph_run_en <= 16'h00ff;
        wr(ADDR_PERIPH_SLEEP_EN, 32'h0003);
        wr(ADDR_SLEEP_CTRL, 32'h1);
        nap();
        chk({31'h0, sleeping}, 32'h1);
        chk({16'h0, periph_clk_en}, 32'h0003);
        chk({29'h0, flash_low_power, sram_power}, 32'h7);
        rc(ADDR_SLEEP_CTRL, 32'h3);
        periph_wake <= 16'h0010;
        repeat (3) @(posedge sys_clk);
        chk({31'h0, sleeping}, 32'h1);
        periph_wake <= 16'h0002;
        repeat (3) @(posedge sys_clk);
        periph_wake <= 16'h0000;
        chk({31'h0, sleeping}, 32'h0);
        chk({16'h0, periph_clk_en}, 32'h00ff);
        wr(ADDR_SLEEP_PWR, 32'h10);
        wr(ADDR_SLEEP_CTRL, 32'h0);
        nap();
        chk({16'h0, periph_clk_en}, 32'h00ff);
        chk({29'h0, flash_low_power, sram_power}, 32'h1);
        periph_wake <= 16'h0020;
        repeat (3) @(posedge sys_clk);
        periph_wake <= 16'h0000;
        chk({31'h0, sleeping}, 32'h0);
    endtask : t_sleep
    initial begin
        repeat (20) @(posedge sys_clk);
        reset <= 1'h0;
        @(posedge sys_clk);
        t_reset_vals();
        t_trim();
        t_pwm();
        t_behav();
        t_cause();
        t_swreset();
        t_sleep();
        close_out();
    end
endmodule : tb_reset_clock_sleep_control
`default_nettype wire
